// file: logic/tmrm_regbank.sv
`timescale 1ns/100ps
`include "tmrm_cfg.svh"

// Summary of operation
// - read-only pointers accept no write; write-only pointers give no readback
// - any data written at the soft reset pointer restores power-on state
// - alternative variant powers both shutdown limits up at the alternative value
// - local high limit is 12 bits: upper at 05/0B, lower nibble at 16
// - local low limit is 12 bits: upper at 06/0C, lower nibble at 17
// - 8-bit pointer selects the register, loaded by every pointer byte, resets to zero
// - pointer is held between transactions so reads repeat the same register
// - returned register bytes are shifted out most significant bit first
module tmrm_regbank
  import tmrm_pkg::*;
#(
  parameter logic ALT_SHUTDOWN = 1'b0,
  parameter logic [7:0] PART_ID = 8'hA7, // value is arbitrary
  parameter logic [7:0] MAKER_ID = 8'h3C // value is arbitrary
)
(
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire tmrm_bus_t i_bus,
  input wire tmrm_meas_t i_meas,
  output logic [7:0] o_rd_data,
  output logic o_rd_valid,
  output logic o_tx_bit,
  output logic o_tx_busy,
  output logic [7:0] o_pointer,
  output tmrm_ctrl_t o_ctrl,
  output logic o_oneshot,
  output logic o_soft_reset
);

  localparam logic [7:0] SHUT_POR = ALT_SHUTDOWN ? `TMRM_RST_SHUT_ALT : `TMRM_RST_SHUT;

  tmrm_regs_t st;
  tmrm_regs_t next_st;
  logic [7:0] rd_byte;

  function automatic tmrm_regs_t por_regs();
    tmrm_regs_t r;
    r = '0;
    r.ptr = `TMRM_RST_ZERO;
    r.status = `TMRM_RST_STATUS;
    r.ctrl.rate = `TMRM_RST_RATE;
    r.ctrl.local_high_limit = {`TMRM_RST_LIMIT_HI, 4'h0};
    r.ctrl.remote_high_limit = {`TMRM_RST_LIMIT_HI, 4'h0};
    r.ctrl.remote_shutdown_limit = SHUT_POR;
    r.ctrl.local_shutdown_limit = SHUT_POR;
    r.ctrl.cfg2 = `TMRM_RST_CFG2;
    r.ctrl.hysteresis = `TMRM_RST_HYST;
    r.ctrl.consec = `TMRM_RST_CONSEC;
    r.ctrl.beta = `TMRM_RST_BETA;
    return r;
  endfunction : por_regs

  function automatic logic [7:0] nib(input logic [3:0] n);
    return {n, 4'h0};
  endfunction : nib

  // pointers that reach a stored or action register on write
  function automatic logic is_writable(input logic [7:0] p);
    logic w;
    w = 1'b0;
    case (p)
      `TMRM_WP_CFG1, `TMRM_WP_RATE, `TMRM_WP_LHL_HI, `TMRM_WP_LLO_HI,
      `TMRM_WP_RHL_HI, `TMRM_WP_RLO_HI, `TMRM_WP_ONESHOT,
      `TMRM_RP_RHL_LO, `TMRM_RP_RLO_LO, `TMRM_RP_LHL_LO, `TMRM_RP_LLO_LO,
      `TMRM_RP_NFAC, `TMRM_RP_RSHUT, `TMRM_RP_CFG2, `TMRM_RP_CHMASK,
      `TMRM_RP_LSHUT, `TMRM_RP_HYST, `TMRM_RP_CONSEC, `TMRM_RP_BETA,
      `TMRM_WP_SWRST: begin
        w = 1'b1;
      end
      default: begin
        w = 1'b0;
      end
    endcase
    return w;
  endfunction : is_writable

  // write-only pointers fall to the default and read zero
  function automatic logic [7:0] read_mux(input tmrm_regs_t r);
    logic [7:0] d;
    d = 8'h00;
    case (r.ptr)
      `TMRM_RP_LT_HI: d = r.lt[11:4];
      `TMRM_RP_RT_HI: d = r.rt[11:4];
      `TMRM_RP_STATUS: d = r.status;
      `TMRM_RP_CFG1: d = r.ctrl.cfg1;
      `TMRM_RP_RATE: d = r.ctrl.rate;
      `TMRM_RP_LHL_HI: d = r.ctrl.local_high_limit[11:4];
      `TMRM_RP_LLO_HI: d = r.ctrl.local_low_limit[11:4];
      `TMRM_RP_RHL_HI: d = r.ctrl.remote_high_limit[11:4];
      `TMRM_RP_RLO_HI: d = r.ctrl.remote_low_limit[11:4];
      `TMRM_RP_RT_LO: d = nib(r.rt[3:0]);
      `TMRM_RP_RHL_LO: d = nib(r.ctrl.remote_high_limit[3:0]);
      `TMRM_RP_RLO_LO: d = nib(r.ctrl.remote_low_limit[3:0]);
      `TMRM_RP_LT_LO: d = nib(r.lt[3:0]);
      `TMRM_RP_LHL_LO: d = nib(r.ctrl.local_high_limit[3:0]);
      `TMRM_RP_LLO_LO: d = nib(r.ctrl.local_low_limit[3:0]);
      `TMRM_RP_NFAC: d = r.ctrl.ideality;
      `TMRM_RP_RSHUT: d = r.ctrl.remote_shutdown_limit;
      `TMRM_RP_CFG2: d = r.ctrl.cfg2;
      `TMRM_RP_CHMASK: d = r.ctrl.chan_exclude;
      `TMRM_RP_LSHUT: d = r.ctrl.local_shutdown_limit;
      `TMRM_RP_HYST: d = r.ctrl.hysteresis;
      `TMRM_RP_CONSEC: d = r.ctrl.consec;
      `TMRM_RP_BETA: d = r.ctrl.beta;
      `TMRM_RP_PART: d = PART_ID;
      `TMRM_RP_MAKER: d = MAKER_ID;
      default: d = 8'h00;
    endcase
    return d;
  endfunction : read_mux

  assign rd_byte = read_mux(st);

  always_comb begin
    logic [7:0] wd;
    logic [3:0] wn;
    wd = i_bus.data;
    wn = i_bus.data[`TMRM_NIB_MSB:`TMRM_NIB_LSB];
    next_st = st;
    next_st.oneshot = 1'b0;
    next_st.swrst = 1'b0;
    next_st.rd_valid = 1'b0;
    // engine results land before any bus action in the same cycle
    if (i_meas.update) begin
      next_st.lt = i_meas.local_temp;
      next_st.rt = i_meas.remote_temp;
      next_st.status = i_meas.status;
    end
    if (i_bus.rd_req) begin
      next_st.rd_data = rd_byte;
      next_st.rd_valid = 1'b1;
    end
    if (i_bus.ptr_valid) begin
      next_st.ptr = i_bus.data;
    end else if (i_bus.wr_valid) begin
      // read-only pointers have no item here
      case (st.ptr)
        `TMRM_WP_CFG1: next_st.ctrl.cfg1 = wd & `TMRM_MASK_CFG1;
        `TMRM_WP_RATE: next_st.ctrl.rate = wd & `TMRM_MASK_RATE;
        `TMRM_WP_LHL_HI: next_st.ctrl.local_high_limit[11:4] = wd;
        `TMRM_WP_LLO_HI: next_st.ctrl.local_low_limit[11:4] = wd;
        `TMRM_WP_RHL_HI: next_st.ctrl.remote_high_limit[11:4] = wd;
        `TMRM_WP_RLO_HI: next_st.ctrl.remote_low_limit[11:4] = wd;
        `TMRM_WP_ONESHOT: next_st.oneshot = 1'b1;
        `TMRM_RP_RHL_LO: next_st.ctrl.remote_high_limit[3:0] = wn;
        `TMRM_RP_RLO_LO: next_st.ctrl.remote_low_limit[3:0] = wn;
        `TMRM_RP_LHL_LO: next_st.ctrl.local_high_limit[3:0] = wn;
        `TMRM_RP_LLO_LO: next_st.ctrl.local_low_limit[3:0] = wn;
        `TMRM_RP_NFAC: next_st.ctrl.ideality = wd;
        `TMRM_RP_RSHUT: next_st.ctrl.remote_shutdown_limit = wd;
        `TMRM_RP_CFG2: next_st.ctrl.cfg2 = wd & `TMRM_MASK_CFG2;
        `TMRM_RP_CHMASK: next_st.ctrl.chan_exclude = wd & `TMRM_MASK_CHMASK;
        `TMRM_RP_LSHUT: next_st.ctrl.local_shutdown_limit = wd;
        `TMRM_RP_HYST: next_st.ctrl.hysteresis = wd;
        `TMRM_RP_CONSEC: next_st.ctrl.consec = wd & `TMRM_MASK_CONSEC;
        `TMRM_RP_BETA: next_st.ctrl.beta = wd & `TMRM_MASK_BETA;
        `TMRM_WP_SWRST: begin
          // data value is ignored; pointer returns to zero as well
          next_st = por_regs();
          next_st.swrst = 1'b1;
        end
        default: begin
          next_st = next_st;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      st <= por_regs();
    end else begin
      st <= next_st;
    end
  end

  tmrm_tx_shift u_tx_shift (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_load(i_bus.rd_req),
    .i_byte(rd_byte),
    .i_shift(i_bus.tx_shift),
    .o_bit(o_tx_bit),
    .o_busy(o_tx_busy)
  );

  assign o_rd_data = st.rd_data;
  assign o_rd_valid = st.rd_valid;
  assign o_pointer = st.ptr;
  assign o_ctrl = st.ctrl;
  assign o_oneshot = st.oneshot;
  assign o_soft_reset = st.swrst;

  // data strobe aimed at a given pointer, no pointer load in the same cycle
  sequence s_wr_at(logic [7:0] p);
    i_bus.wr_valid && !i_bus.ptr_valid && (st.ptr == p);
  endsequence

  sequence s_rd_at(logic [7:0] p);
    i_bus.rd_req && (st.ptr == p);
  endsequence

  property p_ro_no_write;
    @(posedge i_sys_clk) disable iff (i_reset)
    s_wr_at(`TMRM_RP_LHL_HI) ##0 !i_meas.update
      |=> $stable(st.ctrl) && $stable(st.lt);
  endproperty
  a_ro_no_write: assert property (p_ro_no_write)
    else $error("write at a read-only pointer changed state");

  property p_wo_reads_zero;
    @(posedge i_sys_clk) disable iff (i_reset)
    s_rd_at(`TMRM_WP_ONESHOT) or s_rd_at(`TMRM_WP_SWRST)
      |=> o_rd_valid && (o_rd_data == 8'h00);
  endproperty
  a_wo_reads_zero: assert property (p_wo_reads_zero)
    else $error("write-only pointer gave readback");

  property p_soft_reset;
    @(posedge i_sys_clk) disable iff (i_reset)
    s_wr_at(`TMRM_WP_SWRST)
      |=> o_soft_reset && (o_pointer == 8'h00) && (o_ctrl.rate == `TMRM_RST_RATE)
      ##1 !o_soft_reset;
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("soft reset write did not restore power-on state");

  property p_shut_por;
    @(posedge i_sys_clk) disable iff (i_reset)
    o_soft_reset |-> (o_ctrl.local_shutdown_limit == SHUT_POR)
      && (o_ctrl.remote_shutdown_limit == SHUT_POR);
  endproperty
  a_shut_por: assert property (p_shut_por)
    else $error("shutdown limits not at variant power-on value");

  property p_lhl_split;
    @(posedge i_sys_clk) disable iff (i_reset)
    s_wr_at(`TMRM_WP_LHL_HI)
      |=> (o_ctrl.local_high_limit[11:4] == $past(i_bus.data))
      && $stable(o_ctrl.local_high_limit[3:0]);
  endproperty
  a_lhl_split: assert property (p_lhl_split)
    else $error("local high limit upper byte not stored");

  property p_lhl_lo_write;
    @(posedge i_sys_clk) disable iff (i_reset)
    s_wr_at(`TMRM_RP_LHL_LO)
      |=> (o_ctrl.local_high_limit[3:0] == $past(i_bus.data[7:4]))
      && $stable(o_ctrl.local_high_limit[11:4]);
  endproperty
  a_lhl_lo_write: assert property (p_lhl_lo_write)
    else $error("local high limit low nibble not stored");

  property p_lhl_hi_read;
    @(posedge i_sys_clk) disable iff (i_reset)
    s_rd_at(`TMRM_RP_LHL_HI)
      |=> o_rd_valid && (o_rd_data == $past(o_ctrl.local_high_limit[11:4]));
  endproperty
  a_lhl_hi_read: assert property (p_lhl_hi_read)
    else $error("local high limit upper byte readback wrong");

  property p_lhl_lo_read;
    @(posedge i_sys_clk) disable iff (i_reset)
    s_rd_at(`TMRM_RP_LHL_LO)
      |=> (o_rd_data[3:0] == 4'h0)
      && (o_rd_data[7:4] == $past(o_ctrl.local_high_limit[3:0]));
  endproperty
  a_lhl_lo_read: assert property (p_lhl_lo_read)
    else $error("local high limit low byte readback wrong");

  property p_llo_split;
    @(posedge i_sys_clk) disable iff (i_reset)
    s_wr_at(`TMRM_RP_LLO_LO)
      |=> (o_ctrl.local_low_limit[3:0] == $past(i_bus.data[7:4]))
      && $stable(o_ctrl.local_low_limit[11:4]);
  endproperty
  a_llo_split: assert property (p_llo_split)
    else $error("local low limit low nibble not stored");

  property p_llo_hi_write;
    @(posedge i_sys_clk) disable iff (i_reset)
    s_wr_at(`TMRM_WP_LLO_HI)
      |=> (o_ctrl.local_low_limit[11:4] == $past(i_bus.data))
      && $stable(o_ctrl.local_low_limit[3:0]);
  endproperty
  a_llo_hi_write: assert property (p_llo_hi_write)
    else $error("local low limit upper byte not stored");

  property p_llo_hi_read;
    @(posedge i_sys_clk) disable iff (i_reset)
    s_rd_at(`TMRM_RP_LLO_HI)
      |=> o_rd_valid && (o_rd_data == $past(o_ctrl.local_low_limit[11:4]));
  endproperty
  a_llo_hi_read: assert property (p_llo_hi_read)
    else $error("local low limit upper byte readback wrong");

  property p_llo_lo_read;
    @(posedge i_sys_clk) disable iff (i_reset)
    s_rd_at(`TMRM_RP_LLO_LO)
      |=> o_rd_valid && (o_rd_data == {$past(o_ctrl.local_low_limit[3:0]), 4'h0});
  endproperty
  a_llo_lo_read: assert property (p_llo_lo_read)
    else $error("local low limit low byte readback wrong");

  property p_ptr_load;
    @(posedge i_sys_clk) disable iff (i_reset)
    i_bus.ptr_valid |=> o_pointer == $past(i_bus.data);
  endproperty
  a_ptr_load: assert property (p_ptr_load)
    else $error("pointer not loaded by pointer byte");

  property p_ptr_hold;
    @(posedge i_sys_clk) disable iff (i_reset)
    !i_bus.ptr_valid && !(i_bus.wr_valid && st.ptr == `TMRM_WP_SWRST)
      |=> $stable(o_pointer);
  endproperty
  a_ptr_hold: assert property (p_ptr_hold)
    else $error("pointer moved without a write");

  property p_msb_first;
    @(posedge i_sys_clk) disable iff (i_reset)
    i_bus.rd_req ##1 (!i_bus.rd_req && i_bus.tx_shift)
      |-> (o_tx_bit == o_rd_data[7]) ##1 (o_tx_bit == $past(o_rd_data[6]));
  endproperty
  a_msb_first: assert property (p_msb_first)
    else $error("readback not sent most significant bit first");

  // one byte requested, then eight shifts with no reload in between
  sequence s_byte_out;
    i_bus.rd_req ##1 (!i_bus.rd_req && i_bus.tx_shift) [*8];
  endsequence

  property p_byte_drain;
    @(posedge i_sys_clk) disable iff (i_reset)
    s_byte_out |=> !o_tx_busy && !o_tx_bit;
  endproperty
  a_byte_drain: assert property (p_byte_drain)
    else $error("shifter not idle after eight bits");

  property p_unmapped_write;
    @(posedge i_sys_clk) disable iff (i_reset)
    i_bus.wr_valid && !i_bus.ptr_valid && !is_writable(st.ptr)
      |=> $stable(st.ctrl) && !o_oneshot && !o_soft_reset;
  endproperty
  a_unmapped_write: assert property (p_unmapped_write)
    else $error("write at unmapped pointer changed a register");

  property p_oneshot_write;
    @(posedge i_sys_clk) disable iff (i_reset)
    s_wr_at(`TMRM_WP_ONESHOT)
      |=> o_oneshot && !o_soft_reset && $stable(st.ctrl);
  endproperty
  a_oneshot_write: assert property (p_oneshot_write)
    else $error("one-shot write did not pulse or changed a register");

endmodule : tmrm_regbank

// file: logic/tmrm_cfg.svh
`ifndef TMRM_CFG_SVH
`define TMRM_CFG_SVH

// read pointers
`define TMRM_RP_LT_HI 8'h00
`define TMRM_RP_RT_HI 8'h01
`define TMRM_RP_STATUS 8'h02
`define TMRM_RP_CFG1 8'h03
`define TMRM_RP_RATE 8'h04
`define TMRM_RP_LHL_HI 8'h05
`define TMRM_RP_LLO_HI 8'h06
`define TMRM_RP_RHL_HI 8'h07
`define TMRM_RP_RLO_HI 8'h08
`define TMRM_RP_RT_LO 8'h10
`define TMRM_RP_RHL_LO 8'h13
`define TMRM_RP_RLO_LO 8'h14
`define TMRM_RP_LT_LO 8'h15
`define TMRM_RP_LHL_LO 8'h16
`define TMRM_RP_LLO_LO 8'h17
`define TMRM_RP_NFAC 8'h18
`define TMRM_RP_RSHUT 8'h19
`define TMRM_RP_CFG2 8'h1A
`define TMRM_RP_CHMASK 8'h1F
`define TMRM_RP_LSHUT 8'h20
`define TMRM_RP_HYST 8'h21
`define TMRM_RP_CONSEC 8'h22
`define TMRM_RP_BETA 8'h25
`define TMRM_RP_PART 8'hFD
`define TMRM_RP_MAKER 8'hFE

// write pointers that differ from the read pointer
`define TMRM_WP_CFG1 8'h09
`define TMRM_WP_RATE 8'h0A
`define TMRM_WP_LHL_HI 8'h0B
`define TMRM_WP_LLO_HI 8'h0C
`define TMRM_WP_RHL_HI 8'h0D
`define TMRM_WP_RLO_HI 8'h0E
`define TMRM_WP_ONESHOT 8'h0F
`define TMRM_WP_SWRST 8'hFC

// power-on values
`define TMRM_RST_ZERO 8'h00
`define TMRM_RST_STATUS 8'h80
`define TMRM_RST_RATE 8'h07
`define TMRM_RST_LIMIT_HI 8'h55
`define TMRM_RST_SHUT 8'h55
`define TMRM_RST_SHUT_ALT 8'h69
`define TMRM_RST_CFG2 8'h1C
`define TMRM_RST_HYST 8'h0A
`define TMRM_RST_CONSEC 8'h70
`define TMRM_RST_BETA 8'h08

// implemented bits of partly reserved registers
`define TMRM_MASK_CFG1 8'hE4
`define TMRM_MASK_RATE 8'h0F
`define TMRM_MASK_CFG2 8'h1C
`define TMRM_MASK_CHMASK 8'h03
`define TMRM_MASK_CONSEC 8'h7E
`define TMRM_MASK_BETA 8'h0F

// low nibble fields sit in bits 7..4
`define TMRM_NIB_MSB 7
`define TMRM_NIB_LSB 4
`define TMRM_BIT_CNT_MAX 3'h7

`endif

// file: logic/tmrm_pkg.sv
package tmrm_pkg;

  typedef struct packed {
    logic ptr_valid;
    logic wr_valid;
    logic rd_req;
    logic tx_shift;
    logic [7:0] data;
  } tmrm_bus_t;

  typedef struct packed {
    logic update;
    logic [11:0] local_temp;
    logic [11:0] remote_temp;
    logic [7:0] status;
  } tmrm_meas_t;

  typedef struct packed {
    logic [7:0] cfg1;
    logic [7:0] rate;
    logic [11:0] local_high_limit;
    logic [11:0] local_low_limit;
    logic [11:0] remote_high_limit;
    logic [11:0] remote_low_limit;
    logic [7:0] ideality;
    logic [7:0] remote_shutdown_limit;
    logic [7:0] cfg2;
    logic [7:0] chan_exclude;
    logic [7:0] local_shutdown_limit;
    logic [7:0] hysteresis;
    logic [7:0] consec;
    logic [7:0] beta;
  } tmrm_ctrl_t;

  typedef struct packed {
    logic [7:0] ptr;
    logic [11:0] lt;
    logic [11:0] rt;
    logic [7:0] status;
    tmrm_ctrl_t ctrl;
    logic [7:0] rd_data;
    logic rd_valid;
    logic oneshot;
    logic swrst;
  } tmrm_regs_t;

  typedef enum logic [1:0] {
    TMRM_SH_IDLE = 2'b01,
    TMRM_SH_SEND = 2'b10
  } tmrm_sh_state_t;

  typedef struct packed {
    tmrm_sh_state_t state;
    logic [7:0] shreg;
    logic [2:0] cnt;
  } tmrm_sh_t;

endpackage : tmrm_pkg

// file: logic/tmrm_tx_shift.sv
`timescale 1ns/100ps
`include "tmrm_cfg.svh"

module tmrm_tx_shift
  import tmrm_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_load,
  input wire logic [7:0] i_byte,
  input wire logic i_shift,
  output logic o_bit,
  output logic o_busy
);

  tmrm_sh_t st;
  tmrm_sh_t next_st;

  always_comb begin
    next_st = st;
    unique case (st.state)
      TMRM_SH_IDLE: begin
      end
      TMRM_SH_SEND: begin
        if (i_shift) begin
          next_st.shreg = {st.shreg[6:0], 1'b0};
          next_st.cnt = st.cnt - 3'h1;
          if (st.cnt == 3'h0) begin
            next_st.state = TMRM_SH_IDLE;
          end
        end
      end
    endcase
    // a new read overrides a byte still in flight
    if (i_load) begin
      next_st.shreg = i_byte;
      next_st.cnt = `TMRM_BIT_CNT_MAX;
      next_st.state = TMRM_SH_SEND;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      st <= '{state: TMRM_SH_IDLE, shreg: 8'h00, cnt: 3'h0};
    end else begin
      st <= next_st;
    end
  end

  assign o_bit = st.shreg[7];
  assign o_busy = (st.state == TMRM_SH_SEND);

endmodule : tmrm_tx_shift

// file: verif/tmrm_host_model.sv
`timescale 1ns/100ps
`include "tmrm_cfg.svh"

module tmrm_host_model
  import tmrm_pkg::*;
(
  input wire logic i_sys_clk,
  output tmrm_bus_t o_bus,
  input wire logic [7:0] i_rd_data,
  input wire logic i_rd_valid,
  input wire logic i_tx_bit,
  input wire logic i_tx_busy,
  input wire logic i_oneshot,
  input wire logic i_soft_reset
);
  initial o_bus = '0;

  // strobes {ptr_valid, wr_valid, rd_req, tx_shift}
  task automatic drive(input logic [3:0] s, input logic [7:0] d);
    @(posedge i_sys_clk);
    #1;
    o_bus = {s, d};
  endtask : drive

  // released data lines never keep a stale copy
  task automatic idle();
    drive(4'h0, ~o_bus.data);
  endtask : idle

  task automatic set_ptr(input logic [7:0] p);
    drive(4'h8, p);
    idle();
  endtask : set_ptr

  task automatic write(input logic [7:0] p, input logic [7:0] d, output logic [1:0] pulse);
    drive(4'h8, p);
    drive(4'h4, d);
    idle();
    pulse = {i_oneshot, i_soft_reset};
  endtask : write

  // data value is irrelevant, the pointer alone triggers
  task automatic soft_reset(output logic [1:0] pulse);
    write(`TMRM_WP_SWRST, 8'hA5, pulse);
  endtask : soft_reset

  // st = {rd_valid, busy while sending, busy after eighth shift}
  task automatic read(output logic [7:0] d, output logic [7:0] sh, output logic [2:0] st);
    drive(4'h2, ~o_bus.data);
    drive(4'h1, ~o_bus.data);
    d = i_rd_data;
    st = {i_rd_valid, i_tx_busy, 1'b0};
    sh[7] = i_tx_bit;
    for (int i = 6; i >= 0; i--) begin
      drive(4'h1, ~o_bus.data);
      sh[i] = i_tx_bit;
    end
    idle();
    st[0] = i_tx_busy;
  endtask : read
endmodule : tmrm_host_model

// file: verif/tmrm_regbank_bench.sv
`timescale 1ns/100ps

module tmrm_regbank_bench
  import tmrm_pkg::*;
;
  localparam logic [7:0] PART = 8'h6B; // value is arbitrary
  localparam logic [7:0] MAKER = 8'hC2; // value is arbitrary
  logic sys_clk;
  logic reset;
  tmrm_bus_t bus;
  tmrm_meas_t meas;
  logic [7:0] rd_data;
  logic rd_valid;
  logic tx_bit;
  logic tx_busy;
  logic oneshot;
  logic soft_reset;
  logic [7:0] pointer;
  tmrm_ctrl_t ctrl;
  tmrm_ctrl_t ctrl_alt;
  logic [1:0] pulse;
  int failures;
  int samples_checked;
  // {pointer, power-on value}; 0F and FC write-only, 30 unmapped
  logic [15:0] por_tbl [28] = '{16'h0000, 16'h0100, 16'h0280, 16'h0300, 16'h0407,
    16'h0555, 16'h0600, 16'h0755, 16'h0800, 16'h1000, 16'h1300, 16'h1400, 16'h1500,
    16'h1600, 16'h1700, 16'h1800, 16'h1955, 16'h1A1C, 16'h1F00, 16'h2055, 16'h210A,
    16'h2270, 16'h2508, 16'h0F00, 16'hFC00, 16'h3000, {8'hFD, PART}, {8'hFE, MAKER}};
  // {write pointer, data, read pointer, expected readback}
  logic [31:0] wr_tbl [18] = '{32'h0B5A055A, 32'h16FF16F0, 32'h0C3C063C, 32'h179B1790,
    32'h09FF03E4, 32'h0AFF040F, 32'h0D120712, 32'h0E340834, 32'h13FF13F0, 32'h14A514A0,
    32'h18771877, 32'h19421942, 32'h1AFF1A1C, 32'h1FFF1F03, 32'h20662066, 32'h21112111,
    32'h22FF227E, 32'h25FF250F};
  logic [7:0] bad_tbl [9] = '{8'h00, 8'h01, 8'h02, 8'h05, 8'h10, 8'h15, 8'h30, 8'hFD, 8'hFE};

  tmrm_regbank #(.ALT_SHUTDOWN(1'b0), .PART_ID(PART), .MAKER_ID(MAKER)) DUT (
    .i_sys_clk(sys_clk), .i_reset(reset), .i_bus(bus), .i_meas(meas),
    .o_rd_data(rd_data), .o_rd_valid(rd_valid), .o_tx_bit(tx_bit), .o_tx_busy(tx_busy),
    .o_pointer(pointer), .o_ctrl(ctrl), .o_oneshot(oneshot), .o_soft_reset(soft_reset));
  tmrm_regbank #(.ALT_SHUTDOWN(1'b1), .PART_ID(PART), .MAKER_ID(MAKER)) DUT_ALT (
    .i_sys_clk(sys_clk), .i_reset(reset), .i_bus(bus), .i_meas(meas),
    .o_rd_data(), .o_rd_valid(), .o_tx_bit(), .o_tx_busy(),
    .o_pointer(), .o_ctrl(ctrl_alt), .o_oneshot(), .o_soft_reset());
  tmrm_host_model host (
    .i_sys_clk(sys_clk), .o_bus(bus), .i_rd_data(rd_data), .i_rd_valid(rd_valid),
    .i_tx_bit(tx_bit), .i_tx_busy(tx_busy), .i_oneshot(oneshot), .i_soft_reset(soft_reset));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report();
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  // reads twice without touching the pointer in between
  task automatic read_at(input logic [7:0] p, input logic [7:0] exp);
    logic [7:0] d;
    logic [7:0] sh;
    logic [2:0] st;
    host.set_ptr(p);
    check(16'(pointer), 16'(p));
    host.read(d, sh, st);
    check(16'(d), 16'(exp));
    check(16'(sh), 16'(exp));
    check(16'(st), 16'h0006);
    host.read(d, sh, st);
    check(16'(d), 16'(exp));
  endtask : read_at

  task automatic check_writes();
    foreach (wr_tbl[i]) read_at(wr_tbl[i][15:8], wr_tbl[i][7:0]);
  endtask : check_writes

  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    final_report();
  end

  initial begin
    failures = 0;
    samples_checked = 0;
    reset = 1'b1;
    meas = '0;
    repeat (5) @(posedge sys_clk);
    #1 reset = 1'b0;
    check(16'(pointer), 16'h0000);
    check({ctrl.remote_shutdown_limit, ctrl.local_shutdown_limit}, 16'h5555);
    check({ctrl_alt.remote_shutdown_limit, ctrl_alt.local_shutdown_limit}, 16'h6969);
    foreach (por_tbl[i]) read_at(por_tbl[i][15:8], por_tbl[i][7:0]);
    @(posedge sys_clk);
    #1 meas = '{1'b1, 12'hABC, 12'h123, 8'h5A};
    @(posedge sys_clk);
    #1 meas.update = 1'b0;
    read_at(8'h00, 8'hAB);
    read_at(8'h15, 8'hC0);
    read_at(8'h01, 8'h12);
    read_at(8'h10, 8'h30);
    read_at(8'h02, 8'h5A);
    foreach (wr_tbl[i]) begin
      host.write(wr_tbl[i][31:24], wr_tbl[i][23:16], pulse);
      check(16'(pulse), 16'h0000);
    end
    check_writes();
    check(16'(ctrl.local_high_limit), 16'h05AF);
    check(16'(ctrl.local_low_limit), 16'h03C9);
    // writes where nothing is writable must leave every register alone
    foreach (bad_tbl[i]) host.write(bad_tbl[i], 8'hEE, pulse);
    check_writes();
    read_at(8'h00, 8'hAB);
    read_at(8'hFD, PART);
    host.write(8'h0F, 8'h3C, pulse);
    check(16'(pulse), 16'h0002);
    host.soft_reset(pulse);
    check(16'(pulse), 16'h0001);
    check(16'(pointer), 16'h0000);
    check(16'(ctrl.local_high_limit), 16'h0550);
    foreach (por_tbl[i]) read_at(por_tbl[i][15:8], por_tbl[i][7:0]);
    final_report();
  end
endmodule : tmrm_regbank_bench
